/* common/phase_strap_consts.vh */
// Purpose: shared constants for the phase count and strap control block
// Assumes: 20 MHz system clock
// Notes:   analog levels arrive already quantised by comparators outside this logic
`ifndef PHASE_STRAP_CONSTS_VH
`define PHASE_STRAP_CONSTS_VH

`define REG_COUNT           4
`define REG_WIDTH           8
`define REG_CLEAR_VALUE     8'h00
`define PHASE_REG_INDEX     2'h2
`define PHASE_BIT           6
`define ADDR_STRAP_LOW      7'h46
`define ADDR_STRAP_HIGH     7'h47
`define TABLE_LEGACY        3'h1
`define TABLE_EXTENDED      3'h2
`define TABLE_ALTERNATE     3'h4

`endif

/* logic/pin_sync.v */
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: single clock clk_sys, asynchronous active-low reset
// Notes:   output changes only when stages two and three agree
`timescale 1ns/100ps

module pin_sync
#(
    parameter RESET_LEVEL = 1'b0
)
(
    // clock and reset
    input  wire clk_sys,
    input  wire nrst,
    // pin
    input  wire pin,
    output reg  level
);

reg s1;
reg s2;
reg s3;

always @(posedge clk_sys or negedge nrst)
begin
    if (!nrst)
    begin
        s1    <= RESET_LEVEL;
        s2    <= RESET_LEVEL;
        s3    <= RESET_LEVEL;
        level <= RESET_LEVEL;
    end
    else
    begin
        s1 <= pin;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
        begin
            level <= s3;
        end
    end
end

endmodule // pin_sync

/* logic/phase_count_and_strap_control.v */
// Purpose: enable, active phase count, strap address/clear, table mode and code pass-through
// Assumes: pins pre-quantised to logic levels; register writes come from a serial slave
// Notes:   serial protocol itself lives elsewhere; this holds the config registers
`timescale 1ns/100ps
`include "phase_strap_consts.vh"

// Contract
// - inhibit high forces one phase; register 2 bit 6 ignored, writes can't change count.
// - inhibit low selects one or two phases from register 2 bit 6.
// - inhibit low with bit 6 at default gives two active phases.
// - phase count follows the inhibit pin live, no restart needed.
// - strap low gives address 1000_110x, strap high gives 1000_111x.
// - strap grounded in operation clears every config register to zero.
// - enable low holds controller_enabled, two_phase_active and reference_code low; register writes still land; high enables it.
// - table select level chooses legacy, extended or alternate table and mode.
// - pass eight code inputs straight to reference_code, no table applied, zero while disabled; weak pull up or down per mode.
module phase_count_and_strap_control
(
    // clock and reset
    input  wire       clk_sys,
    input  wire       nrst,
    // board pins
    input  wire       enable_pin,
    input  wire       second_phase_inhibit,
    input  wire       softstart_clear_addr_strap,
    input  wire       strap_tied_high,
    input  wire       table_sel_above_low,
    input  wire       table_sel_above_high,
    input  wire [7:0] voltage_code_inputs,
    // register write port from serial slave
    input  wire       reg_wr,
    input  wire [1:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // status and control outputs
    output reg        controller_enabled,
    output reg        two_phase_active,
    output reg  [6:0] slave_address,
    output reg  [2:0] table_mode,
    output reg        code_pull_up,
    output reg  [7:0] reference_code
);

////////////////////////////////////////////////////////////////////////////////
// synchronised pins

wire en_s;
wire inh_s;
wire strap_s;
wire strap_hi_s;
wire sel_lo_s;
wire sel_hi_s;
wire [7:0] code_s;

// inhibit and strap reset to their safe side: one phase, and no false clear
pin_sync
#(
    .RESET_LEVEL (1'b0)
)
u_en
(
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (enable_pin),
    .level   (en_s)
);

pin_sync
#(
    .RESET_LEVEL (1'b1)
)
u_inh
(
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (second_phase_inhibit),
    .level   (inh_s)
);

pin_sync
#(
    .RESET_LEVEL (1'b1)
)
u_strap
(
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (softstart_clear_addr_strap),
    .level   (strap_s)
);

pin_sync
#(
    .RESET_LEVEL (1'b0)
)
u_sthi
(
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (strap_tied_high),
    .level   (strap_hi_s)
);

pin_sync
#(
    .RESET_LEVEL (1'b0)
)
u_sello
(
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (table_sel_above_low),
    .level   (sel_lo_s)
);

pin_sync
#(
    .RESET_LEVEL (1'b0)
)
u_selhi
(
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (table_sel_above_high),
    .level   (sel_hi_s)
);

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_code
        // bits settle one by one, so a moving code word may be mixed for a cycle
        pin_sync
        #(
            .RESET_LEVEL (1'b0)
        )
        u_code
        (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .pin     (voltage_code_inputs[gi]),
            .level   (code_s[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// configuration registers

reg [7:0] cfg [0:`REG_COUNT-1];
integer i;

// strap clear dominates a write in the same cycle, so a grounded strap always wins
always @(posedge clk_sys or negedge nrst)
begin
    if (!nrst)
    begin
        for (i = 0; i < `REG_COUNT; i = i + 1)
            cfg[i] <= `REG_CLEAR_VALUE;
    end
    else if (!strap_s)
    begin
        for (i = 0; i < `REG_COUNT; i = i + 1)
            cfg[i] <= `REG_CLEAR_VALUE;
    end
    else if (reg_wr)
    begin
        cfg[reg_addr] <= reg_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode selection

reg [2:0] next_table_mode;

always @*
begin
    if (sel_hi_s)
        next_table_mode = `TABLE_ALTERNATE;
    else if (sel_lo_s)
        next_table_mode = `TABLE_EXTENDED;
    else
        next_table_mode = `TABLE_LEGACY;
end

wire bit6_single = cfg[`PHASE_REG_INDEX][`PHASE_BIT];
// inhibit high ignores the register; otherwise clear bit means two phases
wire next_two_phase = en_s & ~inh_s & ~bit6_single;

// the slave address is caught only while disabled so it cannot move mid-transfer
always @(posedge clk_sys or negedge nrst)
begin
    if (!nrst)
    begin
        controller_enabled <= 1'b0;
        two_phase_active   <= 1'b0;
        slave_address      <= `ADDR_STRAP_LOW;
        table_mode         <= `TABLE_LEGACY;
        code_pull_up       <= 1'b1;
        reference_code     <= 8'h00;
        reg_rdata          <= 8'h00;
    end
    else
    begin
        controller_enabled <= en_s;
        two_phase_active   <= next_two_phase;
        if (!en_s)
        begin
            slave_address <= strap_hi_s ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;
            table_mode    <= next_table_mode;
            code_pull_up  <= (next_table_mode != `TABLE_ALTERNATE);
        end
        reference_code <= en_s ? code_s : 8'h00;
        reg_rdata      <= cfg[reg_addr];
    end
end

endmodule // phase_count_and_strap_control

/* verif/strap_board.sv */
// Purpose: board strap, pull-up plus open-drain clear
// Assumes: a released pin reads high through the resistor
// Notes: pulls low only when the bench asks
`timescale 1ns/100ps
module strap_board
(
    input  wire clear_req,
    output wire strap_pin
);
    assign strap_pin = clear_req ? 1'b0 : 1'b1;
endmodule // strap_board

/* verif/phase_strap_assertions.sv */
// Purpose: port checker for phase and strap control
// Assumes: pins held 7 cycles have crossed the syncs
// Notes: bound below
`timescale 1ns/100ps
module phase_strap_checker
(
    // clock and reset
    input wire       clk_sys,
    input wire       nrst,
    // board pins
    input wire       enable_pin,
    input wire       second_phase_inhibit,
    input wire       softstart_clear_addr_strap,
    input wire       strap_tied_high,
    input wire       table_sel_above_low,
    input wire       table_sel_above_high,
    input wire [7:0] voltage_code_inputs,
    // register port
    input wire [1:0] reg_addr,
    input wire [7:0] reg_rdata,
    // status outputs
    input wire       controller_enabled,
    input wire       two_phase_active,
    input wire [6:0] slave_address,
    input wire [2:0] table_mode,
    input wire       code_pull_up,
    input wire [7:0] reference_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // address and table follow the pins only while disabled
    sequence s_idle;
        (!enable_pin && $stable({strap_tied_high, table_sel_above_low, table_sel_above_high}))[*7];
    endsequence
    property p_one; second_phase_inhibit[*7] |-> !two_phase_active; endproperty
    a_one: assert property (p_one) else $error("two phases inhibited");
    property p_bit; (enable_pin && !second_phase_inhibit)[*7] ##0 (reg_addr == 2'h2)[*2]
        |-> two_phase_active == !reg_rdata[6]; endproperty
    a_bit: assert property (p_bit) else $error("phase bit");
    property p_off; !enable_pin[*7] |-> !controller_enabled && !two_phase_active
        && reference_code == 8'h00; endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_on; enable_pin[*7] |-> controller_enabled; endproperty
    a_on: assert property (p_on) else $error("not enabled");
    property p_clr; (!softstart_clear_addr_strap)[*8] |-> reg_rdata == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    property p_addr; s_idle |-> slave_address == {6'h23, strap_tied_high}; endproperty
    a_addr: assert property (p_addr) else $error("slave address");
    property p_tab; s_idle |-> code_pull_up == !table_sel_above_high && table_mode ==
        (table_sel_above_high ? 3'h4 : table_sel_above_low ? 3'h2 : 3'h1); endproperty
    a_tab: assert property (p_tab) else $error("table mode");
    property p_code; (enable_pin && $stable(voltage_code_inputs))[*7]
        |-> reference_code == voltage_code_inputs; endproperty
    a_code: assert property (p_code) else $error("code");
endmodule // phase_strap_checker
bind phase_count_and_strap_control phase_strap_checker u_chk (.*);

/* verif/test_phase_count_and_strap_control.sv */
// Purpose: random bench for phase and strap control
// Assumes: each setting is held 11 cycles
// Notes: all outputs compared as one word
`timescale 1ns/100ps
module test_phase_count_and_strap_control;
    reg clk_sys = 1'h0, nrst, enable_pin, second_phase_inhibit, strap_tied_high, reg_wr, clr;
    reg table_sel_above_low, table_sel_above_high, sample;
    reg [1:0] reg_addr = 2'h2;
    reg [3:0] mode = 4'h1;
    reg [7:0] voltage_code_inputs, reg_wdata;
    reg [28:0] q [$];
    reg [31:0] r, cm = 32'h0;
    wire softstart_clear_addr_strap, controller_enabled, two_phase_active, code_pull_up;
    wire [2:0] table_mode;
    wire [6:0] slave_address;
    wire [7:0] reg_rdata, reference_code;
    int bad_count = 0, n_tests = 0;
    strap_board u_strap (.clear_req(clr), .strap_pin(softstart_clear_addr_strap));
    phase_count_and_strap_control u_dut (.*);
    initial forever #25 clk_sys = ~clk_sys;
    initial #100000
    begin
        bad_count++;
        stop_test;
    end
    task check(input [28:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys)
        if (sample)
            check({controller_enabled, two_phase_active, slave_address, table_mode, code_pull_up,
                reference_code, reg_rdata}, q.pop_front());
    initial
    begin
        {nrst, reg_wr, clr, sample, table_sel_above_low, table_sel_above_high, voltage_code_inputs,
            reg_wdata, strap_tied_high, second_phase_inhibit, enable_pin} = 25'h0;
        void'($urandom(57));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'h1;
        repeat (2)
        begin
            repeat (40)
            begin
                r = $urandom;
                {reg_wdata, voltage_code_inputs, table_sel_above_high, strap_tied_high,
                    second_phase_inhibit, enable_pin} <= r[19:0];
                table_sel_above_low <= r[20] | r[3];
                clr <= r[21] & r[22];
                reg_addr <= r[25:24];
                // write only once the strap level has crossed its sync
                repeat (7) @(posedge clk_sys);
                reg_wr <= r[23];
                @(posedge clk_sys);
                reg_wr <= 1'h0;
                if (r[21] & r[22])
                    cm = 32'h0;
                else if (r[23])
                    cm[{r[25:24], 3'h0} +: 8] = r[19:12];
                mode = r[0] ? mode : {r[2], r[3] ? 3'h4 : r[20] ? 3'h2 : 3'h1};
                q.push_back({r[0], r[0] & !r[1] & !cm[22], 6'h23, mode, !mode[2],
                    r[0] ? r[11:4] : 8'h00, cm[{r[25:24], 3'h0} +: 8]});
                repeat (2) @(posedge clk_sys);
                sample <= 1'h1;
                @(posedge clk_sys);
                sample <= 1'h0;
            end
            // reset in mid-run: outputs fall back at once and every register clears
            nrst <= 1'h0;
            cm = 32'h0;
            mode = 4'h1;
            q.push_back({2'h0, 6'h23, 4'h1, 1'h1, 16'h0000});
            @(posedge clk_sys);
            sample <= 1'h1;
            @(posedge clk_sys);
            sample <= 1'h0;
            nrst <= 1'h1;
        end
        // let the last comparison run before the verdict
        @(posedge clk_sys);
        stop_test;
    end
endmodule // test_phase_count_and_strap_control
